// ===== port_a_pkg.sv
// Behaviour
// (RULE_01) Eight pins, each input or output.
// (RULE_02) Direction bit one floats the driver.
// (RULE_03) Direction bit zero drives the latch.
// (RULE_04) Level reads pins; level write sets latch.
// (RULE_05) Latch register reads back latched value.
// (RULE_06) Oscillator pins 6,7 read zero everywhere.
// (RULE_07) Oscillator select decides pins 6,7 use.
// (RULE_08) Clock-out drives core clock over four.
// (RULE_09) Reset: pins 0-3,5 analog; pin 4 digital.
// (RULE_10) Analog pin reads low digitally.
// (RULE_11) Analog select bits choose analog pins.
// (RULE_12) Software keeps analog pins as inputs.
// (RULE_13) Comparator reference overrides pin 0, reads low.
// (RULE_14) Enabled peripheral takes the pin over.
// (RULE_15) Pin 4 feeds timer clock when input.
// (RULE_16) Pin 5 feeds serial slave select when input.
// (RULE_17) Pin levels synchronised before reading.
package port_a_pkg;

    localparam int PIN_COUNT = 8;
    localparam int SYNC_STAGES = 3;

    // Register byte offsets on the APB.
    localparam logic [7:0] OFFSET_PIN_LEVEL = 8'h00;
    localparam logic [7:0] OFFSET_OUTPUT_LATCH = 8'h04;
    localparam logic [7:0] OFFSET_PIN_DIRECTION = 8'h08;
    localparam logic [7:0] OFFSET_ANALOG_SELECT = 8'h0c;
    localparam logic [7:0] OFFSET_PIN_CONFIG = 8'h10;

    // Reset values.
    localparam logic [7:0] RESET_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] RESET_PIN_DIRECTION = 8'hff;
    localparam logic [4:0] RESET_ANALOG_SELECT = 5'h1f;
    localparam logic [3:0] RESET_OSC_SELECT = 4'h8;

    // Analog select field: bit n enables channel on pin n for n<4, bit 4 on pin 5.
    localparam int ANALOG_FIELD_WIDTH = 5;
    // Pin configuration register fields.
    localparam int CFG_OSC_LSB = 0;
    localparam int CFG_OSC_WIDTH = 4;
    localparam int CFG_CMP_REF_BIT = 4;

    // Pin positions with alternate functions.
    localparam int PIN_CMP_REF = 0;
    localparam int PIN_TIMER_CLOCK = 4;
    localparam int PIN_SLAVE_SELECT = 5;
    localparam int PIN_CLOCK_OUT = 6;
    localparam int PIN_CLOCK_IN = 7;

    // Oscillator select encodings.
    localparam logic [3:0] OSC_EXT_CLOCK_IO = 4'h5;
    localparam logic [3:0] OSC_EXT_CLOCK_OUT = 4'h7;
    localparam logic [3:0] OSC_INTERNAL_IO = 4'h8;
    localparam logic [3:0] OSC_INTERNAL_CLOCK_OUT = 4'h9;

    // Clock-out divides the core clock by this ratio.
    localparam int CLOCK_OUT_DIVIDE = 4;
    localparam logic [1:0] CLOCK_OUT_HALF = 2'h1;

    // Drive toward the pads.
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] enable;
    } pad_drive_t;

    // Register access answer.
    typedef struct packed {
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } apb_answer_t;

endpackage

// ===== pin_sync.sv
`timescale 1ns/100ps
// Three-stage input synchroniser; the held level changes only when stages two and three agree.
module pin_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Asynchronous input and settled level
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // Accept a bit only once the two late stages agree, which drops single-cycle glitches.
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
        end
    end

    // Stage one is read by stage two alone.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end

endmodule

// ===== port_a_io.sv
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
// Eight-pin general purpose port with APB registers and alternate-function overrides.
module port_a_io (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads
    input wire logic [7:0] pad_in,
    output port_a_pkg::pad_drive_t pad_drive,
    // Alternate functions
    output logic timer_external_clock_input,
    output logic slave_select_n,
    output logic oscillator_owns_pins,
    output logic [7:0] analog_pin_enable
);

    // Register state.
    logic [7:0] output_latch_register;
    logic [7:0] pin_direction_register;
    logic [4:0] analog_select_control;
    logic [3:0] osc_select;
    logic comparator_reference_output;
    logic [7:0] next_output_latch_register;
    logic [7:0] next_pin_direction_register;
    logic [4:0] next_analog_select_control;
    logic [3:0] next_osc_select;
    logic next_comparator_reference_output;

    // Bus answer state.
    port_a_pkg::apb_answer_t answer;
    port_a_pkg::apb_answer_t next_answer;

    // Clock-out divider and registered pin-side outputs.
    logic [1:0] divide_count;
    logic [1:0] next_divide_count;
    logic divided_clock_output;
    logic next_divided_clock_output;
    port_a_pkg::pad_drive_t next_pad_drive;
    logic next_timer_external_clock_input;
    logic next_slave_select_n;
    logic next_oscillator_owns_pins;
    logic [7:0] next_analog_pin_enable;

    // Derived pin ownership.
    logic [7:0] pin_level;
    logic [7:0] gpio_mask;
    logic [7:0] analog_mask;
    logic [7:0] read_level;
    logic clock_out_on;
    logic access;
    logic write_strobe;

    // Oscillator select to pin-6 and pin-7 general I/O ownership.
    function automatic logic [1:0] osc_gpio_pins(input logic [3:0] sel);
        logic [1:0] pins;
        pins = 2'h0;
        case (sel)
            port_a_pkg::OSC_INTERNAL_IO: pins = 2'h3;
            port_a_pkg::OSC_INTERNAL_CLOCK_OUT: pins = 2'h2;
            port_a_pkg::OSC_EXT_CLOCK_IO: pins = 2'h1;
            port_a_pkg::OSC_EXT_CLOCK_OUT: pins = 2'h0;
            default: pins = 2'h0;
        endcase
        return pins;
    endfunction

    // Oscillator select to clock-out on pin 6.
    function automatic logic osc_clock_out(input logic [3:0] sel);
        return (sel == port_a_pkg::OSC_INTERNAL_CLOCK_OUT) || (sel == port_a_pkg::OSC_EXT_CLOCK_OUT);
    endfunction

    // Pad levels pass four flops (three stages and the held level) before any reader sees them.
    pin_sync #(
        .WIDTH(port_a_pkg::PIN_COUNT)
    ) u_pin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(pad_in),
        .level(pin_level)
    ); // RULE_17

    // Work out which pins general I/O still owns.
    always_comb
    begin
        gpio_mask = 8'hff;
        gpio_mask[port_a_pkg::PIN_CLOCK_IN:port_a_pkg::PIN_CLOCK_OUT] = osc_gpio_pins(osc_select); // RULE_07
        clock_out_on = osc_clock_out(osc_select); // RULE_08
        analog_mask = 8'h00;
        analog_mask[3:0] = analog_select_control[3:0]; // RULE_11
        analog_mask[port_a_pkg::PIN_SLAVE_SELECT] = analog_select_control[4]; // RULE_11
        // Digital reads go low under analog, comparator or oscillator ownership.
        read_level = pin_level & gpio_mask & ~analog_mask; // RULE_10 RULE_06
        if (comparator_reference_output)
        begin
            read_level[port_a_pkg::PIN_CMP_REF] = 1'b0; // RULE_13
        end
    end

    // Bus decode: the write and the registered answer both land at the access edge.
    assign access = psel && penable && !answer.ready;
    assign write_strobe = access && pwrite;

    // Next register values from bus writes.
    always_comb
    begin
        next_output_latch_register = output_latch_register;
        next_pin_direction_register = pin_direction_register;
        next_analog_select_control = analog_select_control;
        next_osc_select = osc_select;
        next_comparator_reference_output = comparator_reference_output;
        if (write_strobe)
        begin
            case (paddr)
                port_a_pkg::OFFSET_PIN_LEVEL,
                port_a_pkg::OFFSET_OUTPUT_LATCH:
                begin
                    // Writes to oscillator-owned bits are dropped so they stay zero.
                    next_output_latch_register = pwdata[7:0] & gpio_mask; // RULE_04 RULE_06
                end
                port_a_pkg::OFFSET_PIN_DIRECTION:
                begin
                    next_pin_direction_register = (pwdata[7:0] & gpio_mask) | ~gpio_mask; // RULE_01
                end
                port_a_pkg::OFFSET_ANALOG_SELECT:
                begin
                    next_analog_select_control = pwdata[port_a_pkg::ANALOG_FIELD_WIDTH-1:0]; // RULE_11
                end
                port_a_pkg::OFFSET_PIN_CONFIG:
                begin
                    next_osc_select = pwdata[port_a_pkg::CFG_OSC_LSB +: port_a_pkg::CFG_OSC_WIDTH]; // RULE_07
                    next_comparator_reference_output = pwdata[port_a_pkg::CFG_CMP_REF_BIT];
                end
                default:
                begin
                    next_output_latch_register = output_latch_register;
                end
            endcase
        end
        // Handing pins to the oscillator clears their latch bits.
        next_output_latch_register = next_output_latch_register & gpio_mask; // RULE_06
        // Owned direction bits are held at one, so pins handed back come up as inputs, not stale outputs.
        next_pin_direction_register = next_pin_direction_register | ~gpio_mask; // RULE_06
    end

    // Registered read data and answer.
    always_comb
    begin
        next_answer = '0;
        if (access)
        begin
            next_answer.ready = 1'b1;
            if (!pwrite)
            begin
                case (paddr)
                    port_a_pkg::OFFSET_PIN_LEVEL: next_answer.rdata = {24'h000000, read_level}; // RULE_04
                    port_a_pkg::OFFSET_OUTPUT_LATCH:
                        next_answer.rdata = {24'h000000, output_latch_register & gpio_mask}; // RULE_05
                    port_a_pkg::OFFSET_PIN_DIRECTION:
                        next_answer.rdata = {24'h000000, pin_direction_register & gpio_mask}; // RULE_06
                    port_a_pkg::OFFSET_ANALOG_SELECT: next_answer.rdata = {27'h0000000, analog_select_control};
                    port_a_pkg::OFFSET_PIN_CONFIG:
                        next_answer.rdata = {27'h0000000, comparator_reference_output, osc_select};
                    default: next_answer.slverr = 1'b1;
                endcase
            end
            else
            begin
                case (paddr)
                    port_a_pkg::OFFSET_PIN_LEVEL,
                    port_a_pkg::OFFSET_OUTPUT_LATCH,
                    port_a_pkg::OFFSET_PIN_DIRECTION,
                    port_a_pkg::OFFSET_ANALOG_SELECT,
                    port_a_pkg::OFFSET_PIN_CONFIG: next_answer.slverr = 1'b0;
                    default: next_answer.slverr = 1'b1;
                endcase
            end
        end
    end

    // Clock-out divider: toggles every half ratio so the pin runs at the core rate over four.
    always_comb
    begin
        next_divide_count = divide_count + 2'h1;
        next_divided_clock_output = divided_clock_output;
        if (divide_count == port_a_pkg::CLOCK_OUT_HALF)
        begin
            next_divide_count = 2'h0;
            next_divided_clock_output = !divided_clock_output; // RULE_08
        end
    end

    // Pad drive and alternate-function outputs.
    always_comb
    begin
        // Direction register still governs analog pins; software must keep them as inputs.
        next_pad_drive.level = output_latch_register; // RULE_03
        next_pad_drive.enable = ~pin_direction_register & gpio_mask; // RULE_02 RULE_03 RULE_12
        if (comparator_reference_output)
        begin
            next_pad_drive.enable[port_a_pkg::PIN_CMP_REF] = 1'b0; // RULE_13 RULE_14
        end
        if (clock_out_on)
        begin
            next_pad_drive.level[port_a_pkg::PIN_CLOCK_OUT] = divided_clock_output; // RULE_08
            next_pad_drive.enable[port_a_pkg::PIN_CLOCK_OUT] = 1'b1; // RULE_08 RULE_14
        end
        next_timer_external_clock_input = pin_direction_register[port_a_pkg::PIN_TIMER_CLOCK]
            & pin_level[port_a_pkg::PIN_TIMER_CLOCK]; // RULE_15
        next_slave_select_n = !pin_direction_register[port_a_pkg::PIN_SLAVE_SELECT]
            | pin_level[port_a_pkg::PIN_SLAVE_SELECT]; // RULE_16
        next_oscillator_owns_pins = gpio_mask[port_a_pkg::PIN_CLOCK_IN:port_a_pkg::PIN_CLOCK_OUT] != 2'h3;
        next_analog_pin_enable = analog_mask; // RULE_10
    end

    // Register everything; reset puts pins 0-3 and 5 in analog mode and all pins as inputs.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            output_latch_register <= port_a_pkg::RESET_OUTPUT_LATCH;
            pin_direction_register <= port_a_pkg::RESET_PIN_DIRECTION; // RULE_02
            analog_select_control <= port_a_pkg::RESET_ANALOG_SELECT; // RULE_09
            osc_select <= port_a_pkg::RESET_OSC_SELECT;
            comparator_reference_output <= 1'b0;
            answer <= '0;
            divide_count <= 2'h0;
            divided_clock_output <= 1'b0;
            pad_drive <= '0;
            timer_external_clock_input <= 1'b0;
            slave_select_n <= 1'b1;
            oscillator_owns_pins <= 1'b0;
            analog_pin_enable <= 8'h2f; // RULE_09
        end
        else
        begin
            output_latch_register <= next_output_latch_register;
            pin_direction_register <= next_pin_direction_register;
            analog_select_control <= next_analog_select_control;
            osc_select <= next_osc_select;
            comparator_reference_output <= next_comparator_reference_output;
            answer <= next_answer;
            divide_count <= next_divide_count;
            divided_clock_output <= next_divided_clock_output;
            pad_drive <= next_pad_drive;
            timer_external_clock_input <= next_timer_external_clock_input;
            slave_select_n <= next_slave_select_n;
            oscillator_owns_pins <= next_oscillator_owns_pins;
            analog_pin_enable <= next_analog_pin_enable;
        end
    end

    // Bus outputs straight from the answer flops.
    assign prdata = answer.rdata;
    assign pready = answer.ready;
    assign pslverr = answer.slverr;

endmodule

// ===== port_a_checker.sv
`timescale 1ns/100ps
// Watches the port's APB answers and its alternate-function outputs.
module port_a_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pads and alternate functions
    input wire port_a_pkg::pad_drive_t pad_drive,
    input wire logic timer_external_clock_input,
    input wire logic slave_select_n,
    input wire logic [7:0] analog_pin_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // First access-phase cycle of a request, and the one-cycle answer to it.
    sequence access_start;
        psel && penable && !pready;
    endsequence
    sequence answer;
        pready ##1 !pready;
    endsequence
    a_ready_one_wait: assert property (access_start |=> answer)
        else $error("pready not one cycle after access");
    a_bad_addr_error: assert property ((access_start and (paddr > 8'h10)) |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_good_addr_ok: assert property ((access_start and (paddr <= 8'h10 && paddr[1:0] == 2'h0)) |=> !pslverr)
        else $error("mapped access refused");
    a_quiet_idle: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("answer outside pready");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_analog_map: assert property (analog_pin_enable[7:6] == 2'h0 && !analog_pin_enable[4])
        else $error("analog enable on a digital-only pin");
    a_timer_gated: assert property (timer_external_clock_input |-> !pad_drive.enable[4])
        else $error("timer input while pin drives");
    a_select_idle: assert property (pad_drive.enable[5] |-> slave_select_n)
        else $error("slave select active while pin drives");
    a_analog_low: assert property (pready && paddr == 8'h00 |-> (prdata[7:0] & analog_pin_enable) == 8'h0)
        else $error("analog pin read high");
endmodule

bind port_a_io port_a_checker chk_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_drive(pad_drive),
    .timer_external_clock_input(timer_external_clock_input), .slave_select_n(slave_select_n),
    .analog_pin_enable(analog_pin_enable));

// ===== port_a_pads.sv
`timescale 1ns/100ps
// Board side of the eight pads.
module port_a_pads (
    // Clock
    input wire logic clk,
    // Device and board drive
    input wire port_a_pkg::pad_drive_t pad_drive,
    input wire logic [7:0] ext_level,
    input wire logic [7:0] ext_en,
    // Resolved levels
    output logic [7:0] pad_in
);
    logic [7:0] wander = 8'h5a;
    // A floating pad changes every cycle, so a stale value never looks valid.
    always @(posedge clk)
        wander <= ~wander;
    // The device driver wins where enabled, then the board, else the pad floats.
    always_comb
        pad_in = (pad_drive.enable & pad_drive.level) | (~pad_drive.enable & ((ext_en & ext_level) | (~ext_en & wander)));
endmodule

// ===== port_a_io_test.sv
`timescale 1ns/100ps
// Drives the port over APB and the pads, comparing against a register model.
module port_a_io_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pad_in;
    port_a_pkg::pad_drive_t pad_drive;
    logic timer_external_clock_input;
    logic slave_select_n;
    logic oscillator_owns_pins;
    logic [7:0] analog_pin_enable;
    logic [7:0] ext_level = 8'hff;
    logic [7:0] ext_en = 8'hff;
    logic [31:0] seed = 32'h58d6f41a;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int lat = 0, dir = 32'hff, asel = 32'h1f, cfg = 32'h8;
    int osc_list[5] = '{32'h0, 32'h5, 32'h7, 32'h9, 32'h8};

    port_a_io dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pad_in(pad_in), .pad_drive(pad_drive), .timer_external_clock_input(timer_external_clock_input),
        .slave_select_n(slave_select_n), .oscillator_owns_pins(oscillator_owns_pins),
        .analog_pin_enable(analog_pin_enable));
    port_a_pads pads (.clk(clk), .pad_drive(pad_drive), .ext_level(ext_level), .ext_en(ext_en), .pad_in(pad_in));

    initial
        forever #2.5 clk = ~clk;

    // Cuts a hang short; the whole run needs fewer than a thousand cycles.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count = bad_count + 1;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Pins held by the oscillator for each select value.
    function automatic int om();
        case (cfg[3:0])
            4'h8: return 0;
            4'h9: return 32'h40;
            4'h5: return 32'h80;
            default: return 32'hc0;
        endcase
    endfunction

    function automatic int am();
        return (asel & 32'hf) | ((asel & 32'h10) << 1);
    endfunction

    function automatic int exp_rd(input logic [7:0] a);
        case (a)
            8'h00: return ((~dir & lat) | (dir & ext_level)) & ~am() & ~om() & ~((cfg >> 4) & 1) & 32'hff;
            8'h04: return lat;
            8'h08: return dir & ~om();
            8'h0c: return asel;
            8'h10: return cfg;
            default: return 0;
        endcase
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is sampled high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        // Answer is taken at the very edge where pready is seen high, then the request drops.
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Writes a register and updates the model; oscillator pins drop writes.
    task automatic wreg(input logic [7:0] a, input int v);
        apb(1'b1, a, v);
        case (a)
            8'h00, 8'h04: lat = v & ~om() & 32'hff;
            8'h08: dir = ((v & ~om()) | om()) & 32'hff;
            8'h0c: asel = v & 32'h1f;
            8'h10: cfg = v & 32'h1f;
            default: ;
        endcase
        lat = lat & ~om();
        dir = dir | om();
        chk(err, a > 8'h10);
    endtask

    // Lets the synchroniser settle, then compares pads, outputs and every register.
    task automatic check_all();
        int en;
        int co;
        repeat (6) @(posedge clk);
        @(negedge clk);
        co = (cfg[3:0] == 4'h9 || cfg[3:0] == 4'h7) ? 32'h40 : 32'h0;
        en = (~dir & ~om() & ~((cfg >> 4) & 1) & 32'hff) | co;
        chk(pad_drive.enable, en);
        chk(pad_drive.level & en & ~co, lat & en & ~co);
        chk(analog_pin_enable, am());
        chk(oscillator_owns_pins, om() != 0);
        chk(timer_external_clock_input, dir[4] & ext_level[4]);
        chk(slave_select_n, dir[5] ? ext_level[5] : 1'b1);
        for (int a = 0; a <= 20; a += 4)
        begin
            apb(1'b0, a[7:0], xs());
            chk(rd, exp_rd(a[7:0]));
            chk(err, a > 16);
        end
    endtask

    task automatic count_clock_out();
        logic last;
        int n;
        n = 0;
        last = pad_drive.level[6];
        repeat (8)
        begin
            @(negedge clk);
            n += (pad_drive.level[6] !== last);
            last = pad_drive.level[6];
        end
        chk(n, 4);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        check_all();
        wreg(8'h14, xs());
        check_all();
        $display("reset and refusal test done");
        wreg(8'h0c, 32'h0);
        repeat (6)
        begin
            ext_level <= 8'(xs());
            wreg(8'h08, xs());
            wreg(8'(xs() & 32'h4), xs());
            check_all();
        end
        $display("direction and latch test done");
        foreach (osc_list[i])
        begin
            wreg(8'h10, osc_list[i]);
            wreg(8'h08, 32'h0);
            wreg(8'h04, 32'hff);
            check_all();
            if (osc_list[i] == 32'h9 || osc_list[i] == 32'h7)
                count_clock_out();
        end
        $display("oscillator test done");
        wreg(8'h10, 32'h18);
        ext_en <= 8'hfe;
        check_all();
        ext_en <= 8'hff;
        wreg(8'h10, 32'h8);
        $display("comparator test done");
        repeat (3)
        begin
            ext_level <= 8'(xs());
            wreg(8'h08, 32'hff);
            wreg(8'h0c, xs());
            check_all();
        end
        $display("analog test done");
        tally_and_finish();
    end
endmodule
